// ### irq_pkg.sv
package irq_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_OFS     = 8'h00;
  localparam logic [7:0] GROUP_A_OFS = 8'h06;
  localparam logic [7:0] GROUP_B_OFS = 8'h07;
  localparam logic [7:0] EN_A_OFS    = 8'h08;
  localparam logic [7:0] EN_B_OFS    = 8'h09;
  localparam logic [7:0] EVT_STS_OFS = 8'h10;
  localparam logic [7:0] EVT_CLR_OFS = 8'h11;
  localparam logic [7:0] EVT_EN_OFS  = 8'h12;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int MODE_BIT      = 7;
  localparam int A_HIGH_BIT    = 6;
  localparam int A_LOW_BIT     = 5;
  localparam int A_DONE_BIT    = 4;
  localparam int A_TX_BIT      = 3;
  localparam int A_RX_BIT      = 2;
  localparam int A_ERR_BIT     = 1;
  localparam int A_SOF_BIT     = 0;
  localparam int B_GLOBAL_BIT  = 6;
  localparam int B_CARD_BIT    = 5;
  localparam int B_SW_TOP      = 5;
  localparam int EN_INVERT_BIT = 7;
  localparam int EN_PINEN_BIT  = 6;
  localparam int EN_DRIVE_BIT  = 7;
  localparam int EVT_GLOBAL    = 0;
  localparam int EVT_BADCMD    = 1;

  // ---------------------------------------------------------------
  // reset values and codes
  // ---------------------------------------------------------------
  localparam logic [6:0] FLAGS_RST = 7'h00;
  localparam logic [7:0] EN_RST    = 8'h00;
  localparam logic [1:0] EVT_RST   = 2'h0;
  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [3:0] CMD_IDLE  = 4'h0;
  localparam logic [3:0] CMD_COUNT = 4'hC;

  typedef struct packed {
    logic       fifo_high_alert_status;
    logic       fifo_low_alert_status;
    logic       tx_done;
    logic       rx_done;
    logic       sof_detect;
    logic       fifo_write_error;
    logic       fifo_overflow_error;
    logic       protocol_error;
    logic       no_data_error;
    logic       integrity_error;
    logic       card_detect;
    logic [4:0] counter_underflow;
  } core_events_t;

  typedef struct packed {
    logic       level;
    logic       oe;
  } pin_drive_t;

endpackage

// ### irq_flags.sv
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
// Notes on behaviour
// - bit 7 of write selects set or clear
// - group a: ones change, zeros keep
// - group b: software touches bits 5..0 only
// - high alert status latches flag bit 6
// - low alert status latches flag bit 5
// - command finishing itself sets done flag
// - host writing idle does not set flag
// - transmit finished sets bit 3
// - receive end sets bit 2 regardless
// - any of five errors sets bit 1
// - frame start detection sets bit 0
// - enabled flag set raises global flag
// - card detection sets group b bit 5
// - counter n underflow sets bit n
// - enable bits gate flags into global
// - pin needs enable; invert bit flips level
// - drive select: push-pull or open-drain
module irq_flags #(
  parameter int CMD_W = 4
) (
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  clk_en,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  input  wire irq_pkg::core_events_t core_events,
  input  wire logic                  cmd_finished,
  output logic      [CMD_W-1:0]      cmd_active,
  input  wire logic                  irq_pin_i,
  output logic                       irq_pin_o,
  output logic                       irq_pin_oe,
  output logic                       host_irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [6:0]       group_a_reg;
  logic [6:0]       group_b_reg;
  logic [7:0]       en_a_reg;
  logic [7:0]       en_b_reg;
  logic [CMD_W-1:0] cmd_reg;
  logic [1:0]       evt_sts_reg;
  logic [1:0]       evt_en_reg;
  logic [6:0]       group_a_next;
  logic [6:0]       group_b_next;
  logic [6:0]       hw_set_a;
  logic [6:0]       hw_set_b;
  logic             any_error;
  logic             global_level;
  logic             global_prev_reg;
  logic             bad_cmd;
  logic             pin_level;
  irq_pkg::pin_drive_t drive;

  // applies a masked set or clear; hardware sets win over a clear
  function automatic logic [6:0] apply_write(
    input logic [6:0] cur,
    input logic [6:0] mask,
    input logic       mode,
    input logic [6:0] hw_set
  );
    logic [6:0] tmp;
    tmp = mode ? (cur | mask) : (cur & ~mask);
    return tmp | hw_set;
  endfunction

  function automatic logic hit(input logic [7:0] ofs);
    return reg_wr && (reg_addr == ofs);
  endfunction

  // ---------------------------------------------------------------
  // command field
  // ---------------------------------------------------------------
  // codes at or above the known count are treated as unrecognised
  // a process, not an assign: hit() reads the strobe and address from module scope
  always_comb begin
    bad_cmd = hit(irq_pkg::CMD_OFS)
              && (reg_wdata[CMD_W-1:0] >= CMD_W'(irq_pkg::CMD_COUNT));
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cmd_reg <= CMD_W'(irq_pkg::CMD_IDLE);
    end else if (clk_en) begin
      if (bad_cmd) begin
        cmd_reg <= CMD_W'(irq_pkg::CMD_IDLE);
      end else if (hit(irq_pkg::CMD_OFS)) begin
        cmd_reg <= reg_wdata[CMD_W-1:0];
      end else if (cmd_finished && cmd_reg != CMD_W'(irq_pkg::CMD_IDLE)) begin
        cmd_reg <= CMD_W'(irq_pkg::CMD_IDLE);
      end
    end
  end

  assign cmd_active = cmd_reg;

  // ---------------------------------------------------------------
  // hardware event sources
  // ---------------------------------------------------------------
  assign any_error = core_events.fifo_write_error
                   | core_events.fifo_overflow_error
                   | core_events.protocol_error
                   | core_events.no_data_error
                   | core_events.integrity_error;

  always_comb begin
    hw_set_a = 7'h00;
    // alert flags latch from the level, so they stay set while status is high
    hw_set_a[irq_pkg::A_HIGH_BIT] = core_events.fifo_high_alert_status;
    hw_set_a[irq_pkg::A_LOW_BIT]  = core_events.fifo_low_alert_status;
    // a host write of the idle code is not a self finish
    hw_set_a[irq_pkg::A_DONE_BIT] = bad_cmd
        || (cmd_finished && cmd_reg != CMD_W'(irq_pkg::CMD_IDLE)
            && !hit(irq_pkg::CMD_OFS));
    hw_set_a[irq_pkg::A_TX_BIT]   = core_events.tx_done;
    hw_set_a[irq_pkg::A_RX_BIT]   = core_events.rx_done;
    hw_set_a[irq_pkg::A_ERR_BIT]  = any_error;
    hw_set_a[irq_pkg::A_SOF_BIT]  = core_events.sof_detect;
  end

  always_comb begin
    hw_set_b = 7'h00;
    hw_set_b[irq_pkg::B_CARD_BIT] = core_events.card_detect;
    hw_set_b[4:0] = core_events.counter_underflow;
  end

  // ---------------------------------------------------------------
  // global request
  // ---------------------------------------------------------------
  assign global_level = |(group_a_reg & en_a_reg[6:0])
                      | |(group_b_reg[5:0] & en_b_reg[5:0]);

  // ---------------------------------------------------------------
  // request flag registers
  // ---------------------------------------------------------------
  always_comb begin
    group_a_next = group_a_reg | hw_set_a;
    if (hit(irq_pkg::GROUP_A_OFS)) begin
      group_a_next = apply_write(group_a_reg, reg_wdata[6:0],
                                 reg_wdata[irq_pkg::MODE_BIT], hw_set_a);
    end
  end

  always_comb begin
    group_b_next = group_b_reg | hw_set_b;
    if (hit(irq_pkg::GROUP_B_OFS)) begin
      // mask out the global position so software never moves it
      group_b_next = apply_write(group_b_reg, {1'b0, reg_wdata[5:0]},
                                 reg_wdata[irq_pkg::MODE_BIT], hw_set_b);
    end
    group_b_next[irq_pkg::B_GLOBAL_BIT] = global_level;
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      group_a_reg <= irq_pkg::FLAGS_RST;
    end else if (clk_en) begin
      group_a_reg <= group_a_next;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      group_b_reg <= irq_pkg::FLAGS_RST;
    end else if (clk_en) begin
      group_b_reg <= group_b_next;
    end
  end

  // ---------------------------------------------------------------
  // enable registers
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      en_a_reg <= irq_pkg::EN_RST;
      en_b_reg <= irq_pkg::EN_RST;
    end else if (clk_en) begin
      if (hit(irq_pkg::EN_A_OFS)) begin
        en_a_reg <= reg_wdata;
      end
      if (hit(irq_pkg::EN_B_OFS)) begin
        en_b_reg <= reg_wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // interrupt pin
  // ---------------------------------------------------------------
  assign pin_level = (group_b_reg[irq_pkg::B_GLOBAL_BIT]
                      & en_b_reg[irq_pkg::EN_PINEN_BIT])
                     ^ en_a_reg[irq_pkg::EN_INVERT_BIT];

  // open drain only pulls low; the high level comes from the pull-up
  always_comb begin
    drive.level = pin_level;
    drive.oe    = en_b_reg[irq_pkg::EN_DRIVE_BIT] | ~pin_level;
  end

  assign irq_pin_o  = drive.level;
  assign irq_pin_oe = drive.oe;

  // ---------------------------------------------------------------
  // block event status, clear and enable
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      global_prev_reg <= 1'b0;
    end else if (clk_en) begin
      global_prev_reg <= group_b_reg[irq_pkg::B_GLOBAL_BIT];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      evt_sts_reg <= irq_pkg::EVT_RST;
    end else if (clk_en) begin
      logic [1:0] clr;
      logic [1:0] set;
      clr = hit(irq_pkg::EVT_CLR_OFS) ? reg_wdata[1:0] : 2'h0;
      set = {bad_cmd,
             group_b_reg[irq_pkg::B_GLOBAL_BIT] & ~global_prev_reg};
      evt_sts_reg <= (evt_sts_reg & ~clr) | set;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      evt_en_reg <= irq_pkg::EVT_RST;
    end else if (clk_en && hit(irq_pkg::EVT_EN_OFS)) begin
      evt_en_reg <= reg_wdata[1:0];
    end
  end

  assign host_irq = |(evt_sts_reg & evt_en_reg);

  // ---------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= irq_pkg::READ_ZERO;
    end else if (clk_en) begin
      reg_rdata <= irq_pkg::READ_ZERO;
      if (reg_rd) begin
        unique case (reg_addr)
          irq_pkg::CMD_OFS:     reg_rdata <= 8'(cmd_reg);
          irq_pkg::GROUP_A_OFS: reg_rdata <= {1'b0, group_a_reg};
          irq_pkg::GROUP_B_OFS: reg_rdata <= {1'b0, group_b_reg};
          irq_pkg::EN_A_OFS:    reg_rdata <= en_a_reg;
          irq_pkg::EN_B_OFS:    reg_rdata <= en_b_reg;
          irq_pkg::EVT_STS_OFS: reg_rdata <= {6'h00, evt_sts_reg};
          irq_pkg::EVT_EN_OFS:  reg_rdata <= {6'h00, evt_en_reg};
          default:              reg_rdata <= irq_pkg::READ_ZERO;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  property p_set_mode;
    clk_en && reg_wr && reg_addr == irq_pkg::GROUP_A_OFS && reg_wdata[7] && reg_wdata[0]
      |=> group_a_reg[0];
  endproperty
  a_set_mode: assert property (p_set_mode) else $error("set write lost");

  property p_keep_zero;
    clk_en && reg_wr && reg_addr == irq_pkg::GROUP_A_OFS && !reg_wdata[3]
      && !core_events.tx_done
      |=> group_a_reg[3] == $past(group_a_reg[3]);
  endproperty
  a_keep_zero: assert property (p_keep_zero) else $error("unmasked bit moved");

  property p_clear;
    clk_en && reg_wr && reg_addr == irq_pkg::GROUP_B_OFS && !reg_wdata[7] && reg_wdata[1]
      && !core_events.counter_underflow[1] |=> !group_b_reg[1];
  endproperty
  a_clear: assert property (p_clear) else $error("clear write lost");

  property p_high;
    clk_en && core_events.fifo_high_alert_status |=> group_a_reg[6];
  endproperty
  a_high: assert property (p_high) else $error("high alert not latched");

  property p_bad_cmd;
    clk_en && bad_cmd |=> cmd_reg == CMD_W'(irq_pkg::CMD_IDLE) && group_a_reg[4];
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("bad command kept");

  property p_idle_write;
    clk_en && reg_wr && reg_addr == irq_pkg::CMD_OFS && reg_wdata[CMD_W-1:0] == 0
      && !group_a_reg[4] |=> !group_a_reg[4];
  endproperty
  a_idle_write: assert property (p_idle_write) else $error("idle write set flag");

  property p_error;
    clk_en && core_events.protocol_error |=> group_a_reg[1];
  endproperty
  a_error: assert property (p_error) else $error("error not summarised");

  property p_counter;
    clk_en && core_events.counter_underflow[4] |=> group_b_reg[4];
  endproperty
  a_counter: assert property (p_counter) else $error("underflow missed");

  property p_global;
    clk_en && group_a_reg[0] && en_a_reg[0] |=> group_b_reg[6];
  endproperty
  a_global: assert property (p_global) else $error("global not raised");

  property p_gate;
    clk_en && (group_a_reg & en_a_reg[6:0]) == 0
      && (group_b_reg[5:0] & en_b_reg[5:0]) == 0 |=> !group_b_reg[6];
  endproperty
  a_gate: assert property (p_gate) else $error("disabled flag leaked");

  property p_pin;
    !en_b_reg[6] |-> irq_pin_o == en_a_reg[7];
  endproperty
  a_pin: assert property (p_pin) else $error("pin not gated");

  property p_drive;
    en_b_reg[7] |-> irq_pin_oe;
  endproperty
  a_drive: assert property (p_drive) else $error("push-pull released");

  property p_race;
    clk_en && reg_wr && reg_addr == irq_pkg::GROUP_A_OFS && !reg_wdata[7] && reg_wdata[0]
      && core_events.sof_detect |=> group_a_reg[0];
  endproperty
  a_race: assert property (p_race) else $error("event lost to clear");

  property p_low;
    clk_en && core_events.fifo_low_alert_status |=> group_a_reg[5];
  endproperty
  a_low: assert property (p_low) else $error("low alert not latched");

  property p_done;
    clk_en && cmd_finished && cmd_reg != CMD_W'(irq_pkg::CMD_IDLE)
      && !(reg_wr && reg_addr == irq_pkg::CMD_OFS)
      |=> cmd_reg == CMD_W'(irq_pkg::CMD_IDLE) && group_a_reg[4];
  endproperty
  a_done: assert property (p_done) else $error("self finish not flagged");

  property p_tx;
    clk_en && core_events.tx_done |=> group_a_reg[3];
  endproperty
  a_tx: assert property (p_tx) else $error("transmit done missed");

  property p_rx;
    clk_en && core_events.rx_done |=> group_a_reg[2];
  endproperty
  a_rx: assert property (p_rx) else $error("receive done missed");

  property p_card;
    clk_en && core_events.card_detect |=> group_b_reg[5];
  endproperty
  a_card: assert property (p_card) else $error("card detect missed");

endmodule

// ### irq_pin_model.sv
`timescale 1ns/10ps
// -------------------------------------------------------------
// host side of the interrupt pin
// -------------------------------------------------------------
// the host board carries a pull-up, so a released open-drain line
// reads high; an undriven net would otherwise settle by chance
module irq_pin_model (
  input  wire logic irq_pin_o,
  input  wire logic irq_pin_oe,
  output logic      pin_wire
);
  assign pin_wire = irq_pin_oe ? irq_pin_o : 1'b1;
endmodule

// ### interrupt_request_flags_tb_top.sv
`timescale 1ns/10ps
module interrupt_request_flags_tb_top;
  logic                  sys_clk;
  logic                  sys_rst;
  logic                  clk_en;
  logic                  reg_wr;
  logic                  reg_rd;
  logic                  cmd_finished;
  logic [7:0]            reg_addr;
  logic [7:0]            reg_wdata;
  logic [7:0]            reg_rdata;
  logic [7:0]            rd_val;
  logic [3:0]            cmd_active;
  logic                  irq_pin_o;
  logic                  irq_pin_oe;
  logic                  host_irq;
  logic                  pin_wire;
  irq_pkg::core_events_t core_events;
  int                    fails;
  int                    checks_done;
  // expected group a / group b contents for event bit i of core_events
  logic [7:0] exp_a [16] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h02,
                             8'h02, 8'h02, 8'h02, 8'h01, 8'h04, 8'h08, 8'h20, 8'h40};
  logic [7:0] exp_b [16] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h00, 8'h00,
                             8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  irq_flags #(.CMD_W(4)) DUT (
    .sys_clk      (sys_clk),
    .sys_rst      (sys_rst),
    .clk_en       (clk_en),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_wr       (reg_wr),
    .reg_rd       (reg_rd),
    .reg_rdata    (reg_rdata),
    .core_events  (core_events),
    .cmd_finished (cmd_finished),
    .cmd_active   (cmd_active),
    .irq_pin_i    (pin_wire),
    .irq_pin_o    (irq_pin_o),
    .irq_pin_oe   (irq_pin_oe),
    .host_irq     (host_irq)
  );

  irq_pin_model host (
    .irq_pin_o  (irq_pin_o),
    .irq_pin_oe (irq_pin_oe),
    .pin_wire   (pin_wire)
  );

  // -------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    #1;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask

  task automatic pulse(input logic [15:0] ev);
    @(posedge sys_clk);
    core_events <= irq_pkg::core_events_t'(ev);
    @(posedge sys_clk);
    core_events <= '0;
  endtask

  task automatic pin_chk(input logic [7:0] exp);
    check({5'h00, pin_wire, irq_pin_oe, irq_pin_o}, exp);
  endtask

  task automatic summarize;
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  task automatic t_mask_write;
    wr(irq_pkg::GROUP_A_OFS, 8'hFF);
    rd(irq_pkg::GROUP_A_OFS);
    check(rd_val, 8'h7F);
    wr(irq_pkg::GROUP_A_OFS, 8'h05);
    rd(irq_pkg::GROUP_A_OFS);
    check(rd_val, 8'h7A);
    wr(irq_pkg::GROUP_A_OFS, 8'h7F);
    rd(irq_pkg::GROUP_A_OFS);
    check(rd_val, 8'h00);
    wr(irq_pkg::GROUP_B_OFS, 8'hFF);
    rd(irq_pkg::GROUP_B_OFS);
    check(rd_val, 8'h3F);
    wr(irq_pkg::GROUP_B_OFS, 8'h7F);
    rd(irq_pkg::GROUP_B_OFS);
    check(rd_val, 8'h00);
  endtask

  // with the enable low neither a write nor an event may reach the flags
  task automatic t_freeze;
    @(posedge sys_clk);
    clk_en <= 1'b0;
    wr(irq_pkg::GROUP_A_OFS, 8'hFF);
    pulse(16'h0010);
    @(posedge sys_clk);
    clk_en <= 1'b1;
    rd(irq_pkg::GROUP_A_OFS);
    check(rd_val, 8'h00);
    rd(irq_pkg::GROUP_B_OFS);
    check(rd_val, 8'h00);
  endtask

  // every event line alone, enables off so the global flag must stay low
  task automatic t_events;
    for (int i = 0; i < 16; i++) begin
      pulse(16'h0001 << i);
      rd(irq_pkg::GROUP_A_OFS);
      check(rd_val, exp_a[i]);
      rd(irq_pkg::GROUP_B_OFS);
      check(rd_val, exp_b[i]);
      wr(irq_pkg::GROUP_A_OFS, 8'h7F);
      wr(irq_pkg::GROUP_B_OFS, 8'h7F);
    end
  endtask

  task automatic t_hold_race;
    pulse(16'h8000);
    @(posedge sys_clk);
    reg_addr    <= irq_pkg::GROUP_A_OFS;
    reg_wdata   <= 8'h01;
    reg_wr      <= 1'b1;
    core_events <= irq_pkg::core_events_t'(16'h0800);
    @(posedge sys_clk);
    reg_wr      <= 1'b0;
    core_events <= '0;
    rd(irq_pkg::GROUP_A_OFS);
    check(rd_val, 8'h41);
    wr(irq_pkg::GROUP_A_OFS, 8'h7F);
  endtask

  task automatic t_command;
    wr(irq_pkg::CMD_OFS, 8'h03);
    check({4'h0, cmd_active}, 8'h03);
    @(posedge sys_clk);
    cmd_finished <= 1'b1;
    @(posedge sys_clk);
    cmd_finished <= 1'b0;
    rd(irq_pkg::GROUP_A_OFS);
    check(rd_val, 8'h10);
    check({4'h0, cmd_active}, 8'h00);
    wr(irq_pkg::GROUP_A_OFS, 8'h7F);
    wr(irq_pkg::CMD_OFS, 8'h0C);
    rd(irq_pkg::GROUP_A_OFS);
    check(rd_val, 8'h10);
    check({4'h0, cmd_active}, 8'h00);
    rd(irq_pkg::EVT_STS_OFS);
    check(rd_val, 8'h02);
    wr(irq_pkg::EVT_CLR_OFS, 8'h03);
    wr(irq_pkg::GROUP_A_OFS, 8'h7F);
    wr(irq_pkg::CMD_OFS, 8'h0B);
    check({4'h0, cmd_active}, 8'h0B);
    // host idle write lands in the cycle the running command ends
    @(posedge sys_clk);
    reg_addr     <= irq_pkg::CMD_OFS;
    reg_wdata    <= 8'h00;
    reg_wr       <= 1'b1;
    cmd_finished <= 1'b1;
    @(posedge sys_clk);
    reg_wr       <= 1'b0;
    cmd_finished <= 1'b0;
    rd(irq_pkg::GROUP_A_OFS);
    check(rd_val, 8'h00);
    check({4'h0, cmd_active}, 8'h00);
  endtask

  task automatic t_global_pin;
    wr(irq_pkg::EN_A_OFS, 8'h01);
    wr(irq_pkg::EN_B_OFS, 8'hC0);
    rd(irq_pkg::EN_B_OFS);
    check(rd_val, 8'hC0);
    @(posedge sys_clk);
    #1 check(reg_rdata, 8'h00);
    wr(irq_pkg::EVT_EN_OFS, 8'h01);
    pulse(16'h0800);
    rd(irq_pkg::GROUP_B_OFS);
    check(rd_val, 8'h40);
    pin_chk(8'h07);
    check({7'h00, host_irq}, 8'h01);
    wr(irq_pkg::EN_A_OFS, 8'h81);
    pin_chk(8'h02);
    wr(irq_pkg::EN_B_OFS, 8'h40);
    pin_chk(8'h02);
    wr(irq_pkg::EN_A_OFS, 8'h01);
    pin_chk(8'h05);
    wr(irq_pkg::EN_B_OFS, 8'h00);
    pin_chk(8'h02);
    wr(irq_pkg::EVT_EN_OFS, 8'h00);
    check({7'h00, host_irq}, 8'h00);
    rd(irq_pkg::EVT_STS_OFS);
    check(rd_val, 8'h01);
    wr(irq_pkg::EVT_EN_OFS, 8'h01);
    check({7'h00, host_irq}, 8'h01);
    wr(irq_pkg::EVT_CLR_OFS, 8'h01);
    check({7'h00, host_irq}, 8'h00);
    wr(irq_pkg::EN_A_OFS, 8'h00);
    rd(irq_pkg::GROUP_B_OFS);
    check(rd_val, 8'h00);
    wr(irq_pkg::GROUP_A_OFS, 8'h7F);
  endtask

  task automatic t_unmapped;
    rd(8'h3F);
    check(rd_val, 8'h00);
    rd(irq_pkg::EVT_CLR_OFS);
    check(rd_val, 8'h00);
    wr(8'h3F, 8'hFF);
    rd(irq_pkg::GROUP_A_OFS);
    check(rd_val, 8'h00);
  endtask

  // -------------------------------------------------------------
  // clock, reset, sequence
  // -------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // a hang costs a mismatch and ends the run through the same report
  initial begin
    repeat (4000) @(posedge sys_clk);
    fails++;
    summarize();
  end

  initial begin
    fails        = 0;
    checks_done  = 0;
    sys_rst      = 1'b1;
    clk_en       = 1'b1;
    reg_wr       = 1'b0;
    reg_rd       = 1'b0;
    reg_addr     = 8'h00;
    reg_wdata    = 8'h00;
    cmd_finished = 1'b0;
    core_events  = '0;
    repeat (16) @(posedge sys_clk);
    sys_rst <= 1'b0;
    #1 check({6'h00, irq_pin_oe, host_irq}, 8'h02);
    rd(irq_pkg::GROUP_A_OFS);
    check(rd_val, 8'h00);
    rd(irq_pkg::GROUP_B_OFS);
    check(rd_val, 8'h00);
    t_mask_write();
    t_freeze();
    t_events();
    t_hold_race();
    t_command();
    t_global_pin();
    t_unmapped();
    summarize();
  end
endmodule
